// file: dic_regs.vh
`ifndef DIC_REGS_VH
`define DIC_REGS_VH

// =====================================================
// timing
// one millisecond of the 250 MHz system clock
`define DIC_TICK_CYCLES 18'h3_d090
`define DIC_TICK_W 18
`define DIC_DLY_W 16

// =====================================================
// register byte offsets, low address bits decoded
`define DIC_ADR_W 8
`define DIC_ADR_CTRL 8'h00
`define DIC_ADR_ON_DLY 8'h04
`define DIC_ADR_OFF_DLY 8'h08
`define DIC_ADR_STATUS 8'h0c
`define DIC_ADR_IRQ_STAT 8'h10
`define DIC_ADR_IRQ_CLR 8'h14
`define DIC_ADR_IRQ_EN 8'h18

// =====================================================
// control fields
`define DIC_CTRL_W 8
`define DIC_CTRL_RST 8'h04
`define DIC_CTRL_SIM 0
`define DIC_CTRL_INV 1
`define DIC_CTRL_LFD 2
`define DIC_CTRL_EM_LO 3
`define DIC_CTRL_EM_HI 4
`define DIC_CTRL_SUBST 5
`define DIC_CTRL_SIMV 6
`define DIC_CTRL_SIMINV 7
`define DIC_DLY_RST 16'h0000

// error modes
`define DIC_EM_CURRENT 2'h0
`define DIC_EM_SUBST 2'h1
`define DIC_EM_LAST 2'h2

// =====================================================
// status fields
`define DIC_ST_VALUE 0
`define DIC_ST_VALID 1
`define DIC_ST_FAULT 2
`define DIC_ST_ACTIVE 3
`define DIC_ST_RAW 4
`define DIC_ST_COND 5
`define DIC_ST_W 6

// interrupt events
`define DIC_IRQ_W 3
`define DIC_IRQ_CHG 0
`define DIC_IRQ_FLT_SET 1
`define DIC_IRQ_FLT_CLR 2
`define DIC_IRQ_RST 3'h0

`endif

// file: dic_tick.v
`include "dic_regs.vh"

module dic_tick #(
	parameter [`DIC_TICK_W-1:0] TICK_CYCLES = `DIC_TICK_CYCLES
) (
	input wire sys_clk_i,
	input wire sys_rst_i,
	output reg tick_o
);

	reg [`DIC_TICK_W-1:0] cnt_r;

	// =====================================================
	// millisecond enable pulse
	always @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			cnt_r <= {`DIC_TICK_W{1'b0}};
			tick_o <= 1'b0;
		end
		else if (cnt_r >= TICK_CYCLES - 1'b1)
		begin
			cnt_r <= {`DIC_TICK_W{1'b0}};
			tick_o <= 1'b1;
		end
		else
		begin
			cnt_r <= cnt_r + 1'b1;
			tick_o <= 1'b0;
		end
	end

endmodule

// file: dic_delay.v
`include "dic_regs.vh"

module dic_delay (
	input wire sys_clk_i,
	input wire sys_rst_i,
	input wire tick_i,
	input wire d_i,
	input wire [`DIC_DLY_W-1:0] on_ms_i,
	input wire [`DIC_DLY_W-1:0] off_ms_i,
	output reg q_o
);

	reg [`DIC_DLY_W-1:0] cnt_r;
	wire [`DIC_DLY_W-1:0] dly;

	// rising edges use the on delay, falling edges the off delay
	assign dly = d_i ? on_ms_i : off_ms_i;

	// =====================================================
	// transition filter
	// first tick may come early, so the delay lies in (n-1, n] ms
	always @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			cnt_r <= {`DIC_DLY_W{1'b0}};
			q_o <= 1'b0;
		end
		else if (d_i == q_o)
		begin
			// input fell back before expiry: pulse is dropped
			cnt_r <= {`DIC_DLY_W{1'b0}};
		end
		else if (dly == {`DIC_DLY_W{1'b0}})
		begin
			q_o <= d_i;
		end
		else if (tick_i)
		begin
			if (cnt_r + 1'b1 >= dly)
			begin
				q_o <= d_i;
				cnt_r <= {`DIC_DLY_W{1'b0}};
			end
			else
			begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end

endmodule

// file: dic_top.v
// Chosen here: the register offsets and the Wishbone interface to the registers.
`include "dic_regs.vh"

module dic_top #(
	parameter [`DIC_TICK_W-1:0] TICK_CYCLES = `DIC_TICK_CYCLES
) (
	input wire sys_clk_i,
	input wire sys_rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [31:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire module_active_i,
	input wire field_in_i,
	input wire open_wire_i,
	input wire short_i,
	output reg proc_value_o,
	output reg proc_valid_o,
	output reg fault_o,
	output reg chan_active_o,
	output reg irq_o
);

	// =====================================================
	// helpers
	function [31:0] dic_merge;
		input [31:0] old;
		input [31:0] dat;
		input [3:0] sel;
		integer i;
		begin
			dic_merge = old;
			for (i = 0; i < 4; i = i + 1)
			begin
				if (sel[i])
					dic_merge[i*8 +: 8] = dat[i*8 +: 8];
			end
		end
	endfunction

	function dic_hit;
		input [`DIC_ADR_W-1:0] adr;
		input [`DIC_ADR_W-1:0] match_adr;
		begin
			dic_hit = (adr == match_adr);
		end
	endfunction

	// =====================================================
	// declarations
	reg [2:0] pin_s1_r;
	reg [2:0] pin_s2_r;
	reg [`DIC_CTRL_W-1:0] ctrl_r;
	reg [`DIC_DLY_W-1:0] on_dly_r;
	reg [`DIC_DLY_W-1:0] off_dly_r;
	reg [`DIC_IRQ_W-1:0] irq_stat_r;
	reg [`DIC_IRQ_W-1:0] irq_stat_nxt;
	reg [`DIC_IRQ_W-1:0] irq_en_r;
	reg [`DIC_IRQ_W-1:0] irq_clr;
	reg [`DIC_IRQ_W-1:0] irq_ev;
	reg last_r;
	reg val_nxt;
	reg valid_nxt;
	reg [31:0] rd_nxt;
	reg [31:0] ctrl_wr;
	reg [31:0] on_wr;
	reg [31:0] off_wr;
	wire [`DIC_ADR_W-1:0] adr;
	wire req;
	wire wr;
	wire raw;
	wire inv_in;
	wire cond;
	wire tick;
	wire fault;
	wire active;
	wire [1:0] emode;

	assign adr = wb_adr_i[`DIC_ADR_W-1:0];
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = req & wb_we_i;
	assign emode = ctrl_r[`DIC_CTRL_EM_HI:`DIC_CTRL_EM_LO];

	// =====================================================
	// pin synchronisers: field, open wire, short
	always @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			pin_s1_r <= 3'h0;
			pin_s2_r <= 3'h0;
		end
		else
		begin
			pin_s1_r <= {short_i, open_wire_i, field_in_i};
			pin_s2_r <= pin_s1_r;
		end
	end

	assign raw = pin_s2_r[0];
	assign inv_in = raw ^ ctrl_r[`DIC_CTRL_INV];
	// supervision only counts when enabled
	assign fault = ctrl_r[`DIC_CTRL_LFD] & (pin_s2_r[1] | pin_s2_r[2]);
	// module setting drives the channel; no per-channel override exists
	assign active = module_active_i;

	// =====================================================
	// timebase and on/off delay
	dic_tick #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_o(tick)
	);

	dic_delay u_delay (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_i(tick),
		.d_i(inv_in),
		.on_ms_i(on_dly_r),
		.off_ms_i(off_dly_r),
		.q_o(cond)
	);

	// =====================================================
	// process value selection
	always @*
	begin
		val_nxt = cond;
		valid_nxt = 1'b1;
		if (!active)
		begin
			// inactive channel reports nothing usable
			val_nxt = 1'b0;
			valid_nxt = 1'b0;
		end
		else if (ctrl_r[`DIC_CTRL_SIM])
		begin
			val_nxt = ctrl_r[`DIC_CTRL_SIMV];
			valid_nxt = ~ctrl_r[`DIC_CTRL_SIMINV];
		end
		else if (fault)
		begin
			valid_nxt = 1'b0;
			case (emode)
				`DIC_EM_SUBST:
					val_nxt = ctrl_r[`DIC_CTRL_SUBST];
				`DIC_EM_LAST:
					val_nxt = last_r;
				default:
					val_nxt = cond;
			endcase
		end
		else
		begin
			val_nxt = cond;
		end
	end

	// =====================================================
	// output stage and last valid value
	always @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			proc_value_o <= 1'b0;
			proc_valid_o <= 1'b0;
			fault_o <= 1'b0;
			chan_active_o <= 1'b0;
			last_r <= 1'b0;
		end
		else
		begin
			proc_value_o <= val_nxt;
			proc_valid_o <= valid_nxt;
			fault_o <= fault & active;
			chan_active_o <= active;
			// frozen while faulted so the pre-fault value survives
			if (!fault)
				last_r <= cond;
		end
	end

	// =====================================================
	// interrupt events
	always @*
	begin
		irq_ev = `DIC_IRQ_RST;
		irq_ev[`DIC_IRQ_CHG] = val_nxt ^ proc_value_o;
		irq_ev[`DIC_IRQ_FLT_SET] = (fault & active) & ~fault_o;
		irq_ev[`DIC_IRQ_FLT_CLR] = ~(fault & active) & fault_o;
		irq_clr = `DIC_IRQ_RST;
		if (wr && dic_hit(adr, `DIC_ADR_IRQ_CLR) && wb_sel_i[0])
			irq_clr = wb_dat_i[`DIC_IRQ_W-1:0];
		// set wins over a clear in the same cycle
		irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_ev;
	end

	// =====================================================
	// wishbone write path
	always @*
	begin
		ctrl_wr = dic_merge({24'h00_0000, ctrl_r}, wb_dat_i, wb_sel_i);
		on_wr = dic_merge({16'h0000, on_dly_r}, wb_dat_i, wb_sel_i);
		off_wr = dic_merge({16'h0000, off_dly_r}, wb_dat_i, wb_sel_i);
	end

	always @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			ctrl_r <= `DIC_CTRL_RST;
			on_dly_r <= `DIC_DLY_RST;
			off_dly_r <= `DIC_DLY_RST;
			irq_en_r <= `DIC_IRQ_RST;
			irq_stat_r <= `DIC_IRQ_RST;
			irq_o <= 1'b0;
		end
		else
		begin
			irq_stat_r <= irq_stat_nxt;
			irq_o <= |(irq_stat_nxt & irq_en_r);
			if (wr)
			begin
				if (dic_hit(adr, `DIC_ADR_CTRL))
					ctrl_r <= ctrl_wr[`DIC_CTRL_W-1:0];
				if (dic_hit(adr, `DIC_ADR_ON_DLY))
					on_dly_r <= on_wr[`DIC_DLY_W-1:0];
				if (dic_hit(adr, `DIC_ADR_OFF_DLY))
					off_dly_r <= off_wr[`DIC_DLY_W-1:0];
				if (dic_hit(adr, `DIC_ADR_IRQ_EN) && wb_sel_i[0])
					irq_en_r <= wb_dat_i[`DIC_IRQ_W-1:0];
			end
		end
	end

	// =====================================================
	// wishbone read path; unmapped reads zero and still acks
	always @*
	begin
		rd_nxt = 32'h0000_0000;
		case (1'b1)
			dic_hit(adr, `DIC_ADR_CTRL):
				rd_nxt[`DIC_CTRL_W-1:0] = ctrl_r;
			dic_hit(adr, `DIC_ADR_ON_DLY):
				rd_nxt[`DIC_DLY_W-1:0] = on_dly_r;
			dic_hit(adr, `DIC_ADR_OFF_DLY):
				rd_nxt[`DIC_DLY_W-1:0] = off_dly_r;
			dic_hit(adr, `DIC_ADR_STATUS):
			begin
				rd_nxt[`DIC_ST_VALUE] = proc_value_o;
				rd_nxt[`DIC_ST_VALID] = proc_valid_o;
				rd_nxt[`DIC_ST_FAULT] = fault_o;
				rd_nxt[`DIC_ST_ACTIVE] = chan_active_o;
				rd_nxt[`DIC_ST_RAW] = raw;
				rd_nxt[`DIC_ST_COND] = cond;
			end
			dic_hit(adr, `DIC_ADR_IRQ_STAT):
				rd_nxt[`DIC_IRQ_W-1:0] = irq_stat_r;
			dic_hit(adr, `DIC_ADR_IRQ_EN):
				rd_nxt[`DIC_IRQ_W-1:0] = irq_en_r;
			default:
				rd_nxt = 32'h0000_0000;
		endcase
	end

	always @(posedge sys_clk_i)
	begin
		if (sys_rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			// one-cycle ack; dropped the cycle after it is given
			wb_ack_o <= req;
			if (req && !wb_we_i)
				wb_dat_o <= rd_nxt;
			else
				wb_dat_o <= 32'h0000_0000;
		end
	end

endmodule

// file: dic_properties.sv
module dic_chk (
	input wire sys_clk_i,
	input wire sys_rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire module_active_i,
	input wire open_wire_i,
	input wire short_i,
	input wire proc_value_o,
	input wire proc_valid_o,
	input wire fault_o,
	input wire chan_active_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] lf_h;
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// pin history: fault shows only after the synchroniser
	always @(posedge sys_clk_i)
		lf_h <= {lf_h[2:0], open_wire_i | short_i};
	// =====
	// bus
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	property p_ack;
		s_req |=> s_ans;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle");
	property p_ack_src;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_src: assert property (p_ack_src) else $error("ack without request");
	property p_dat0;
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000;
	endproperty
	a_dat0: assert property (p_dat0) else $error("read data not zero");
	// =====
	// channel
	property p_act;
		!$past(sys_rst_i) |-> chan_active_o == $past(module_active_i);
	endproperty
	a_act: assert property (p_act) else $error("active not following");
	sequence s_off;
		!chan_active_o ##1 !chan_active_o;
	endsequence
	property p_idle;
		s_off |-> !proc_value_o && !proc_valid_o && !fault_o;
	endproperty
	a_idle: assert property (p_idle) else $error("inactive channel drives");
	property p_flt_act;
		fault_o |-> chan_active_o || $past(chan_active_o);
	endproperty
	a_flt_act: assert property (p_flt_act) else $error("fault while inactive");
	property p_flt_src;
		$rose(fault_o) |-> |lf_h;
	endproperty
	a_flt_src: assert property (p_flt_src) else $error("fault without pin");
	property p_flt_gone;
		!(|lf_h) && !$past(|lf_h) |-> !fault_o;
	endproperty
	a_flt_gone: assert property (p_flt_gone) else $error("fault stays");
endmodule

bind dic_top dic_chk u_chk (.sys_clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
	.wb_ack_o, .module_active_i, .open_wire_i, .short_i, .proc_value_o, .proc_valid_o,
	.fault_o, .chan_active_o);

// file: dic_field.sv
module dic_field (
	input wire sys_clk_i,
	input wire lvl_i,
	input wire slow_i,
	input wire ow_i,
	input wire sh_i,
	output logic field_o = 1'h0,
	output logic open_o = 1'h0,
	output logic short_o = 1'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic lag_r = 1'h0;
	// a slow contact settles one cycle late
	always @(posedge sys_clk_i)
	begin
		lag_r <= lvl_i;
		field_o <= slow_i ? lag_r : lvl_i;
		open_o <= ow_i;
		short_o <= sh_i;
	end
endmodule

// file: dic_tb.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_i = 1'h0;
	logic sys_rst_i = 1'h1;
	logic wb_cyc_i = 1'h0;
	logic wb_stb_i = 1'h0;
	logic wb_we_i = 1'h0;
	logic [31:0] wb_adr_i = 32'h0000_0000;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [3:0] wb_sel_i = 4'hf;
	logic module_active_i = 1'h0;
	logic lvl = 1'h0, slow = 1'h0, ow = 1'h0, sh = 1'h0, v;
	logic field_in_i, open_wire_i, short_i;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, proc_value_o, proc_valid_o, fault_o, chan_active_o, irq_o;
	logic [63:0] q[$];
	logic [63:0] r;
	int fails = 0;
	int num_checks = 0;
	dic_top #(.TICK_CYCLES(18'h0_000a)) DUT (.sys_clk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .module_active_i,
		.field_in_i, .open_wire_i, .short_i, .proc_value_o, .proc_valid_o, .fault_o,
		.chan_active_o, .irq_o);
	dic_field u_fld (.sys_clk_i, .lvl_i(lvl), .slow_i(slow), .ow_i(ow), .sh_i(sh),
		.field_o(field_in_i), .open_o(open_wire_i), .short_o(short_i));
	initial
		forever #2 sys_clk_i = ~sys_clk_i;
	// =====
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	task results;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= {24'h00_0000, a};
		wb_dat_i <= {24'h00_0000, d};
		do
			@(posedge sys_clk_i);
		while (wb_ack_o !== 1'h1);
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		@(posedge sys_clk_i);
	endtask
	// upper bytes are always compared; they read zero, as the writes here carry data in the low byte only
	task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		q.push_back({24'hff_ffff, m, 24'h00_0000, e & m});
		wb(1'h0, a, 8'h00);
	endtask
	// pins are compared as well as the status word that mirrors them
	task st(input logic [3:0] e);
		@(negedge sys_clk_i);
		chk(32'({chan_active_o, fault_o, proc_valid_o, proc_value_o}), 32'(e));
		@(posedge sys_clk_i);
		rd(8'h0c, {4'h0, e}, 8'h0f);
	endtask
	task tk(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	task irqc(input logic e);
		@(negedge sys_clk_i);
		chk(32'(irq_o), 32'(e));
		@(posedge sys_clk_i);
	endtask
	always @(posedge sys_clk_i)
		if (wb_ack_o === 1'h1 && wb_we_i === 1'h0)
		begin
			r = q.pop_front();
			chk(wb_dat_o & r[63:32], r[31:0]);
		end
	initial
	begin
		#200_000;
		fails++;
		results();
	end
	// =====
	// sequence; status nibble is active, fault, valid, value
	initial
	begin
		void'($urandom(32'hc141));
		tk(16);
		sys_rst_i <= 1'h0;
		tk(1);
		for (int i = 0; i < 8; i++)
			rd(8'(i * 4), i == 0 ? 8'h04 : 8'h00, 8'hff);
		module_active_i <= 1'h1;
		wb(1'h1, 8'h18, 8'h02);
		for (int i = 0; i < 6; i++)
		begin
			v = 1'($urandom);
			slow <= 1'($urandom);
			lvl <= v;
			tk(8);
			st({3'h5, v});
			wb(1'h1, 8'h00, 8'h06);
			tk(8);
			st({3'h5, ~v});
			wb(1'h1, 8'h00, 8'h04);
		end
		for (int i = 0; i < 4; i++)
		begin
			wb(1'h1, 8'h00, {i[1:0], 6'h05});
			tk(3);
			st({2'h2, ~i[1], i[0]});
		end
		wb(1'h1, 8'h00, 8'h04);
		lvl <= 1'h1;
		tk(8);
		ow <= 1'h1;
		tk(8);
		st(4'hd);
		irqc(1'h1);
		wb(1'h1, 8'h18, 8'h00);
		irqc(1'h0);
		rd(8'h10, 8'h02, 8'h02);
		wb(1'h1, 8'h00, 8'h2c);
		tk(3);
		st(4'hd);
		wb(1'h1, 8'h00, 8'h0c);
		tk(3);
		st(4'hc);
		ow <= 1'h0;
		wb(1'h1, 8'h00, 8'h14);
		tk(8);
		sh <= 1'h1;
		tk(8);
		lvl <= 1'h0;
		tk(8);
		st(4'hd);
		wb(1'h1, 8'h00, 8'h10);
		tk(3);
		st(4'ha);
		sh <= 1'h0;
		wb(1'h1, 8'h00, 8'h04);
		wb(1'h1, 8'h04, 8'h03);
		wb(1'h1, 8'h08, 8'h03);
		tk(8);
		wb(1'h1, 8'h14, 8'h07);
		wb(1'h1, 8'h18, 8'h03);
		irqc(1'h0);
		// pulse shorter than the on delay must not reach the value
		lvl <= 1'h1;
		tk(15);
		lvl <= 1'h0;
		tk(50);
		rd(8'h10, 8'h00, 8'h01);
		lvl <= 1'h1;
		tk(14);
		st(4'ha);
		tk(30);
		st(4'hb);
		lvl <= 1'h0;
		tk(14);
		st(4'hb);
		tk(30);
		st(4'ha);
		rd(8'h10, 8'h01, 8'h07);
		irqc(1'h1);
		lvl <= 1'h1;
		module_active_i <= 1'h0;
		tk(40);
		st(4'h0);
		results();
	end
endmodule
